/* verilog/legacy_status_pkg.sv */
// Constants and field layout for the legacy status structure
// Behaviour
// - Condition register mirrors live fault conditions
// - Shutdown-masked condition shuts load down on its rising edge
// - Latch-masked bits hold until register read
// - Summary-enable mask gates bits into system status
// - System status returned by query and poll
// - Service request only from enabled status bits
// - Shared registers behave alike for both users
// - Bits 7..4: under, over voltage, temperature, bus
// - Bits 3..0: current, power, saturation, module fault
// - All masks share condition bit positions
// - Error bit 5: command not allowed, not run
// - Error bit 4: program line too long
// - Error bit 3: unparsable number
// - Error bit 1: numeric value out of range
// - Error bit 0: unrecognised command
// - Error bits 7, 6, 2 reserved, never set
`default_nettype none
package legacy_status_pkg;
  localparam int unsigned STATUS_WIDTH       = 8;
  localparam logic [2:0]  BIT_UNDER_VOLTAGE  = 3'h7;
  localparam logic [2:0]  BIT_OVER_VOLTAGE   = 3'h6;
  localparam logic [2:0]  BIT_OVER_TEMP      = 3'h5;
  localparam logic [2:0]  BIT_BUS_ERROR      = 3'h4;
  localparam logic [2:0]  BIT_CURRENT_LIMIT  = 3'h3;
  localparam logic [2:0]  BIT_POWER_LIMIT    = 3'h2;
  localparam logic [2:0]  BIT_SATURATION     = 3'h1;
  localparam logic [2:0]  BIT_MODULE_FAULT   = 3'h0;
  localparam logic [2:0]  ERR_NOT_ALLOWED    = 3'h5;
  localparam logic [2:0]  ERR_TOO_LONG       = 3'h4;
  localparam logic [2:0]  ERR_NUMERIC        = 3'h3;
  localparam logic [2:0]  ERR_RANGE          = 3'h1;
  localparam logic [2:0]  ERR_UNRECOGNISED   = 3'h0;
  localparam logic [7:0]  ERR_VALID_BITS     = 8'h3B;
  localparam logic [7:0]  MASK_RESET         = 8'h00;
  localparam logic [7:0]  FLAGS_RESET        = 8'h00;
  // Register selectors on the command port
  typedef enum logic [2:0] {
    SEL_CONDITION = 3'b000,
    SEL_LATCH     = 3'b001,
    SEL_SHUTDOWN  = 3'b010,
    SEL_SUMMARY   = 3'b011,
    SEL_ERROR     = 3'b100,
    SEL_STATUS    = 3'b101,
    SEL_SRQ       = 3'b110
  } reg_sel_t;
endpackage : legacy_status_pkg
`default_nettype wire

/* verilog/status_mask_if.sv */
// Mask bundle passed from the register file to the condition logic
`timescale 1ns/10ps
`default_nettype none
interface status_mask_if;
  logic [7:0] latch_mask;
  logic [7:0] shutdown_mask;
  logic [7:0] summary_mask;
  logic       condition_read;
  logic [7:0] condition;
  logic [7:0] summary;
  logic       shutdown;
  modport regs (output latch_mask, output shutdown_mask, output summary_mask,
                output condition_read, input condition, input summary, input shutdown);
  modport cond (input latch_mask, input shutdown_mask, input summary_mask,
                input condition_read, output condition, output summary, output shutdown);
endinterface : status_mask_if
`default_nettype wire

/* verilog/fault_condition_latch.sv */
// Condition register with latch, shutdown and summary gating
`timescale 1ns/10ps
`default_nettype none
module fault_condition_latch (
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       clk_en,
  input  wire logic [7:0] fault_in,
  status_mask_if.cond     m
);
  import legacy_status_pkg::*;

  logic [7:0] held;
  logic [7:0] next_held;
  logic       shutdown_q;
  logic       next_shutdown;
  logic [7:0] prev_fault;

  always_comb begin
    // Latched bit stays until a read sees the condition already gone
    next_held = (held & ~(m.condition_read ? ~fault_in : 8'h00)) | (fault_in & m.latch_mask);
    next_held = next_held & m.latch_mask;
    // Shut down on the rising edge of any shutdown-masked condition
    next_shutdown = shutdown_q | (|(fault_in & ~prev_fault & m.shutdown_mask));
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      held       <= FLAGS_RESET;
      shutdown_q <= 1'b0;
      prev_fault <= FLAGS_RESET;
    end else if (clk_en) begin
      held       <= next_held;
      shutdown_q <= next_shutdown;
      prev_fault <= fault_in;
    end
  end

  assign m.condition = fault_in | held;
  assign m.summary   = m.condition & m.summary_mask;
  assign m.shutdown  = shutdown_q;

  sequence s_latch_set;
    clk_en && fault_in[0] && m.latch_mask[0];
  endsequence

  sequence s_latch_kept;
    clk_en && !m.condition_read && m.latch_mask[0];
  endsequence

  property p_latch_hold;
    @(posedge clk_sys) disable iff (reset)
      s_latch_set ##1 s_latch_kept |-> m.condition[0];
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched bit lost");

  property p_shutdown;
    @(posedge clk_sys) disable iff (reset)
      (clk_en && |(fault_in & ~prev_fault & m.shutdown_mask)) |=> m.shutdown;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("no shutdown");

  property p_summary;
    @(posedge clk_sys) disable iff (reset)
      (m.summary & ~m.summary_mask) == 8'h00;
  endproperty
  a_summary: assert property (p_summary) else $error("summary leaks");

  property p_live;
    @(posedge clk_sys) disable iff (reset)
      (fault_in & ~m.condition) == 8'h00;
  endproperty
  a_live: assert property (p_live) else $error("condition misses fault");
endmodule : fault_condition_latch
`default_nettype wire

/* verilog/legacy_status_structure.sv */
// Legacy status structure: masks, error flags, status and service request
`timescale 1ns/10ps
`default_nettype none
module legacy_status_structure (
  input  wire logic                          clk_sys,
  input  wire logic                          reset,
  input  wire logic                          clk_en,
  input  wire logic [7:0]                    fault_in,
  input  wire logic                          reg_write,
  input  wire logic                          reg_read,
  input  wire legacy_status_pkg::reg_sel_t   reg_sel,
  input  wire logic [7:0]                    reg_wdata,
  output logic      [7:0]                    reg_rdata,
  input  wire logic                          serial_poll,
  input  wire logic                          err_not_allowed,
  input  wire logic                          err_too_long,
  input  wire logic                          err_numeric,
  input  wire logic                          err_range,
  input  wire logic                          err_unrecognised,
  input  wire logic                          load_on_request,
  output logic                               load_on,
  output logic                               load_shutdown,
  output logic [7:0]                         poll_byte,
  output logic                               service_request
);
  import legacy_status_pkg::*;

  status_mask_if m ();

  logic [7:0] latch_mask;
  logic [7:0] shutdown_mask;
  logic [7:0] summary_mask;
  logic [7:0] srq_mask;
  logic [7:0] err_flags;
  logic [7:0] rdata;
  logic       load_on_q;
  logic [7:0] next_latch_mask;
  logic [7:0] next_shutdown_mask;
  logic [7:0] next_summary_mask;
  logic [7:0] next_srq_mask;
  logic [7:0] next_err_flags;
  logic [7:0] next_rdata;
  logic       next_load_on;
  logic [7:0] next_poll_byte;
  logic [7:0] err_set;
  logic       err_read;

  fault_condition_latch u_cond (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .clk_en   (clk_en),
    .fault_in (fault_in),
    .m        (m)
  );

  assign m.latch_mask     = latch_mask;
  assign m.shutdown_mask  = shutdown_mask;
  assign m.summary_mask   = summary_mask;
  assign m.condition_read = clk_en && reg_read && (reg_sel == SEL_CONDITION);

  always_comb begin
    err_set = 8'h00;
    err_set[ERR_NOT_ALLOWED]  = err_not_allowed;
    err_set[ERR_TOO_LONG]     = err_too_long;
    err_set[ERR_NUMERIC]      = err_numeric;
    err_set[ERR_RANGE]        = err_range;
    err_set[ERR_UNRECOGNISED] = err_unrecognised;
    err_read = reg_read && (reg_sel == SEL_ERROR);
    // Read clears, but a new error in the same cycle survives
    next_err_flags = ((err_read ? 8'h00 : err_flags) | err_set) & ERR_VALID_BITS;
    next_latch_mask    = latch_mask;
    next_shutdown_mask = shutdown_mask;
    next_summary_mask  = summary_mask;
    next_srq_mask      = srq_mask;
    if (reg_write) begin
      unique case (reg_sel)
        SEL_LATCH:    next_latch_mask    = reg_wdata;
        SEL_SHUTDOWN: next_shutdown_mask = reg_wdata;
        SEL_SUMMARY:  next_summary_mask  = reg_wdata;
        SEL_SRQ:      next_srq_mask      = reg_wdata;
        default: ;
      endcase
    end
    // Load-on refused while shut down; one flag serves both status users
    next_load_on = load_on_q;
    if (m.shutdown) begin
      next_load_on = 1'b0;
    end else if (load_on_request) begin
      next_load_on = 1'b1;
    end
    if (load_on_request && m.shutdown) begin
      next_err_flags[ERR_NOT_ALLOWED] = 1'b1;
    end
    // Poll byte is a snapshot, so a slow host sees one consistent value
    next_poll_byte = serial_poll ? m.summary : poll_byte;
    unique case (reg_sel)
      SEL_CONDITION: next_rdata = m.condition;
      SEL_LATCH:     next_rdata = latch_mask;
      SEL_SHUTDOWN:  next_rdata = shutdown_mask;
      SEL_SUMMARY:   next_rdata = summary_mask;
      SEL_ERROR:     next_rdata = err_flags;
      SEL_STATUS:    next_rdata = m.summary;
      SEL_SRQ:       next_rdata = srq_mask;
      default:       next_rdata = 8'h00;
    endcase
    if (!reg_read) begin
      next_rdata = rdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      latch_mask    <= MASK_RESET;
      shutdown_mask <= MASK_RESET;
      summary_mask  <= MASK_RESET;
      srq_mask      <= MASK_RESET;
      err_flags     <= FLAGS_RESET;
      rdata         <= FLAGS_RESET;
      load_on_q     <= 1'b0;
      poll_byte     <= FLAGS_RESET;
    end else if (clk_en) begin
      latch_mask    <= next_latch_mask;
      shutdown_mask <= next_shutdown_mask;
      summary_mask  <= next_summary_mask;
      srq_mask      <= next_srq_mask;
      err_flags     <= next_err_flags;
      rdata         <= next_rdata;
      load_on_q     <= next_load_on;
      poll_byte     <= next_poll_byte;
    end
  end

  assign reg_rdata       = rdata;
  assign load_on         = load_on_q;
  assign load_shutdown   = m.shutdown;
  assign service_request = |(m.summary & srq_mask);

  property p_srq;
    @(posedge clk_sys) disable iff (reset)
      service_request |-> |(m.summary & srq_mask);
  endproperty
  a_srq: assert property (p_srq) else $error("service request unjustified");

  property p_reserved;
    @(posedge clk_sys) disable iff (reset)
      (err_flags & ~ERR_VALID_BITS) == 8'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved error bit set");

  sequence s_refused_request;
    clk_en && load_on_request && m.shutdown;
  endsequence

  sequence s_refused_outcome;
    !load_on && err_flags[ERR_NOT_ALLOWED];
  endsequence

  property p_refuse;
    @(posedge clk_sys) disable iff (reset)
      s_refused_request |=> s_refused_outcome;
  endproperty
  a_refuse: assert property (p_refuse) else $error("load on not refused");

  property p_numeric;
    @(posedge clk_sys) disable iff (reset)
      (clk_en && err_numeric) |=> err_flags[ERR_NUMERIC];
  endproperty
  a_numeric: assert property (p_numeric) else $error("numeric error missed");

  property p_poll;
    @(posedge clk_sys) disable iff (reset)
      (clk_en && serial_poll) |=> (poll_byte == $past(m.summary));
  endproperty
  a_poll: assert property (p_poll) else $error("poll byte wrong");

  property p_not_allowed;
    @(posedge clk_sys) disable iff (reset)
      (clk_en && err_not_allowed) |=> err_flags[ERR_NOT_ALLOWED];
  endproperty
  a_not_allowed: assert property (p_not_allowed) else $error("not allowed missed");

  property p_too_long;
    @(posedge clk_sys) disable iff (reset)
      (clk_en && err_too_long) |=> err_flags[ERR_TOO_LONG];
  endproperty
  a_too_long: assert property (p_too_long) else $error("too long missed");

  property p_range;
    @(posedge clk_sys) disable iff (reset)
      (clk_en && err_range) |=> err_flags[ERR_RANGE];
  endproperty
  a_range: assert property (p_range) else $error("range error missed");

  property p_unrecognised;
    @(posedge clk_sys) disable iff (reset)
      (clk_en && err_unrecognised) |=> err_flags[ERR_UNRECOGNISED];
  endproperty
  a_unrecognised: assert property (p_unrecognised) else $error("syntax error missed");

  // Error bits must survive until the host actually reads them
  property p_err_held;
    @(posedge clk_sys) disable iff (reset)
      (clk_en && !err_read) |=> ((err_flags & $past(err_flags)) == $past(err_flags));
  endproperty
  a_err_held: assert property (p_err_held) else $error("error bit lost");

  property p_stay_off;
    @(posedge clk_sys) disable iff (reset)
      (clk_en && m.shutdown) |=> !load_on;
  endproperty
  a_stay_off: assert property (p_stay_off) else $error("load on while shut down");

  // Frozen clock enable must not invent any event; events during the freeze are dropped
  property p_freeze;
    @(posedge clk_sys) disable iff (reset)
      !clk_en |=> ($stable(err_flags) && $stable(load_on)
        && $stable(reg_rdata) && $stable(poll_byte));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  property p_rdata_hold;
    @(posedge clk_sys) disable iff (reset)
      (clk_en && !reg_read) |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  property p_status_query;
    @(posedge clk_sys) disable iff (reset)
      (clk_en && reg_read && reg_sel == SEL_STATUS) |=> (reg_rdata == $past(m.summary));
  endproperty
  a_status_query: assert property (p_status_query) else $error("status query wrong");

  property p_condition_query;
    @(posedge clk_sys) disable iff (reset)
      (clk_en && reg_read && reg_sel == SEL_CONDITION) |=> (reg_rdata == $past(m.condition));
  endproperty
  a_condition_query: assert property (p_condition_query) else $error("condition wrong");

  property p_summary_write;
    @(posedge clk_sys) disable iff (reset)
      (clk_en && reg_write && reg_sel == SEL_SUMMARY) |=> (summary_mask == $past(reg_wdata));
  endproperty
  a_summary_write: assert property (p_summary_write) else $error("summary mask write");

  property p_shutdown_write;
    @(posedge clk_sys) disable iff (reset)
      (clk_en && reg_write && reg_sel == SEL_SHUTDOWN) |=> (shutdown_mask == $past(reg_wdata));
  endproperty
  a_shutdown_write: assert property (p_shutdown_write) else $error("shutdown mask write");

  property p_latch_write;
    @(posedge clk_sys) disable iff (reset)
      (clk_en && reg_write && reg_sel == SEL_LATCH) |=> (latch_mask == $past(reg_wdata));
  endproperty
  a_latch_write: assert property (p_latch_write) else $error("latch mask write");

  // Checked from the condition side so a wrong summary path shows up here
  property p_srq_source;
    @(posedge clk_sys) disable iff (reset)
      service_request == (|(m.condition & summary_mask & srq_mask));
  endproperty
  a_srq_source: assert property (p_srq_source) else $error("service request source");

  property p_poll_hold;
    @(posedge clk_sys) disable iff (reset)
      (clk_en && !serial_poll) |=> $stable(poll_byte);
  endproperty
  a_poll_hold: assert property (p_poll_hold) else $error("poll byte moved");
endmodule : legacy_status_structure
`default_nettype wire

/* verif/host_model.sv */
// Host controller model driving register, poll and command traffic
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic                        clk_sys,
  input  wire logic [7:0]                  reg_rdata,
  input  wire logic [7:0]                  poll_byte,
  output logic                             reg_write,
  output logic                             reg_read,
  output var legacy_status_pkg::reg_sel_t  reg_sel,
  output logic      [7:0]                  reg_wdata,
  output logic                             serial_poll
);
  import legacy_status_pkg::*;
  initial begin
    reg_write   = 1'b0;
    reg_read    = 1'b0;
    reg_sel     = SEL_CONDITION;
    reg_wdata   = 8'h00;
    serial_poll = 1'b0;
  end
  task automatic wr(input reg_sel_t s, input logic [7:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_sel   <= s;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
    // Released data lines never keep the last value
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input reg_sel_t s, output logic [7:0] d);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_sel  <= s;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic poll(output logic [7:0] d);
    @(posedge clk_sys);
    serial_poll <= 1'b1;
    @(posedge clk_sys);
    serial_poll <= 1'b0;
    #1 d = poll_byte;
  endtask : poll
endmodule : host_model
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the legacy status structure
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import legacy_status_pkg::*;
  logic       clk_sys, reset, clk_en, load_on_request;
  logic       load_on, load_shutdown, service_request;
  logic       reg_write, reg_read, serial_poll;
  logic [7:0] fault_in, reg_rdata, poll_byte, reg_wdata, d;
  logic [4:0] err_v;
  reg_sel_t   reg_sel;
  int         error_cnt, check_count;
  reg_sel_t   sl[5] = '{SEL_LATCH, SEL_SHUTDOWN, SEL_SUMMARY, SEL_SRQ, SEL_ERROR};

  legacy_status_structure dut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
    .fault_in(fault_in), .reg_write(reg_write), .reg_read(reg_read), .reg_sel(reg_sel),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .serial_poll(serial_poll),
    .err_not_allowed(err_v[4]), .err_too_long(err_v[3]), .err_numeric(err_v[2]),
    .err_range(err_v[1]), .err_unrecognised(err_v[0]), .load_on_request(load_on_request),
    .load_on(load_on), .load_shutdown(load_shutdown), .poll_byte(poll_byte),
    .service_request(service_request));
  host_model host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .poll_byte(poll_byte),
    .reg_write(reg_write), .reg_read(reg_read), .reg_sel(reg_sel),
    .reg_wdata(reg_wdata), .serial_poll(serial_poll));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done

  task automatic t_reset;
    for (int i = 0; i < 5; i++) begin
      host.rd(sl[i], d);
      chk("reset value", d, 8'h00);
    end
  endtask : t_reset

  task automatic t_masks;
    for (int i = 0; i < 4; i++) begin
      host.wr(sl[i], 8'h5A ^ 8'(i));
      host.rd(sl[i], d);
      chk("mask readback", d, 8'h5A ^ 8'(i));
      host.wr(sl[i], 8'h00);
    end
    // Writes to read-only places must not disturb them
    host.wr(SEL_CONDITION, 8'hFF);
    host.wr(SEL_ERROR, 8'hFF);
    host.rd(SEL_CONDITION, d);
    chk("condition ro", d, 8'h00);
    host.rd(SEL_ERROR, d);
    chk("error ro", d, 8'h00);
  endtask : t_masks

  task automatic t_latch;
    host.wr(SEL_LATCH, 8'h81);
    @(posedge clk_sys) fault_in <= 8'h83;
    repeat (2) @(posedge clk_sys);
    host.rd(SEL_CONDITION, d);
    chk("condition live", d, 8'h83);
    @(posedge clk_sys) fault_in <= 8'h00;
    repeat (2) @(posedge clk_sys);
    host.rd(SEL_CONDITION, d);
    chk("latched held", d, 8'h81);
    host.rd(SEL_CONDITION, d);
    chk("latched cleared", d, 8'h00);
    host.wr(SEL_LATCH, 8'h00);
  endtask : t_latch

  task automatic t_status;
    host.wr(SEL_SUMMARY, 8'h0F);
    @(posedge clk_sys) fault_in <= 8'h35;
    repeat (2) @(posedge clk_sys);
    host.rd(SEL_STATUS, d);
    chk("status query", d, 8'h05);
    host.poll(d);
    chk("poll byte", d, 8'h05);
    host.wr(SEL_SRQ, 8'h04);
    #1 chk("srq enabled", {7'h00, service_request}, 8'h01);
    host.wr(SEL_SRQ, 8'h10);
    #1 chk("srq masked", {7'h00, service_request}, 8'h00);
    @(posedge clk_sys) fault_in <= 8'h00;
  endtask : t_status

  task automatic t_errors;
    @(posedge clk_sys) err_v <= 5'h1F;
    @(posedge clk_sys) err_v <= 5'h00;
    host.rd(SEL_ERROR, d);
    chk("error all", d, 8'h3B);
    host.rd(SEL_ERROR, d);
    chk("error cleared", d, 8'h00);
    @(posedge clk_sys) err_v <= 5'h02;
    @(posedge clk_sys) err_v <= 5'h00;
    host.rd(SEL_ERROR, d);
    chk("error range", d, 8'h02);
  endtask : t_errors

  task automatic t_freeze;
    @(posedge clk_sys);
    clk_en <= 1'b0;
    err_v  <= 5'h01;
    @(posedge clk_sys) err_v <= 5'h00;
    @(posedge clk_sys) clk_en <= 1'b1;
    host.rd(SEL_ERROR, d);
    chk("frozen error", d, 8'h00);
  endtask : t_freeze

  task automatic t_restart;
    @(posedge clk_sys) reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    #1 chk("reset clears shutdown", {6'h00, load_shutdown, load_on}, 8'h00);
    host.rd(SEL_SHUTDOWN, d);
    chk("shutdown mask reset", d, 8'h00);
    host.rd(SEL_CONDITION, d);
    chk("condition after reset", d, 8'h40);
  endtask : t_restart

  task automatic t_shutdown;
    host.wr(SEL_SHUTDOWN, 8'h40);
    @(posedge clk_sys) load_on_request <= 1'b1;
    @(posedge clk_sys) load_on_request <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 chk("load on", {6'h00, load_shutdown, load_on}, 8'h01);
    @(posedge clk_sys) fault_in <= 8'h40;
    repeat (3) @(posedge clk_sys);
    #1 chk("shut down", {6'h00, load_shutdown, load_on}, 8'h02);
    @(posedge clk_sys) load_on_request <= 1'b1;
    @(posedge clk_sys) load_on_request <= 1'b0;
    host.rd(SEL_ERROR, d);
    chk("refused on", d, 8'h20);
    chk("still off", {7'h00, load_on}, 8'h00);
  endtask : t_shutdown

  // Whole run is about 110 cycles; the 5000-cycle limit leaves wide margin
  initial begin
    #(8 * 5000);
    error_cnt++;
    test_done;
  end

  initial begin
    clk_en          = 1'b1;
    reset           = 1'b1;
    fault_in        = 8'h00;
    err_v           = 5'h00;
    load_on_request = 1'b0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset;
    t_masks;
    t_latch;
    t_status;
    t_errors;
    t_freeze;
    t_shutdown;
    t_restart;
    test_done;
  end
endmodule : tb_top
`default_nettype wire
